// >>> rtl/sicd_irq_select.sv
// Interrupt flag condition selector with interrupt pin drive
// Behaviour
// RQ1 - Prox A mode bits 5:4, active with enable: 00 every, 01 cross, 11 above
// RQ2 - Prox B mode bits 7:6, active with enable: 00 every, 01 cross, 11 above
// RQ3 - Prox C mode bits 1:0 of second register, same three codes
// RQ4 - Ambient mode bits 2:0, bit 3 reserved; enable 00 sets no ambient flag
// RQ5 - Enable 01 with mode 000 sets ambient flag 0 per visible sample
// RQ6 - Enable bit 0, mode x01: visible leaving window sets ambient flag 0
// RQ7 - Enable bit 0, mode x11: infrared leaving window sets ambient flag 0
// RQ8 - Enable bit 1, mode 10x: visible entering window sets ambient flag 1
// RQ9 - Enable bit 1, mode 11x: infrared entering window sets ambient flag 1
// RQ10 - Window ambient decoding exists only on later sequencer revisions
// RQ11 - Response mode bits 3:2, with enable; 00 flags every response write
// RQ12 - Response mode 01 flags only error responses; codes 1x reserved
// RQ13 - Second register resets to zero, bits 7:4 reserved
// RQ14 - With output enable, pin driven low when any flag and enable match
// RQ15 - Clear mode 0: flags stay set until host clears them
// RQ16 - Clear mode 1 with above mode: flag drops once no longer above
// RQ17 - Ambient enable bits gate the matching ambient flag onto the pin
// RQ18 - Crossing: comparison result differs from previous measurement's
// RQ19 - Prox mode 10 sets no flag
`timescale 1ns/100ps
`default_nettype none
module sicd_irq_select #(
  parameter int MEAS_W = 16,
  parameter bit WINDOW_DECODE = 1'b1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Register access port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata_q,
  // Configuration from neighbouring registers
  input wire logic [sicd_pkg::SICD_FLAG_W-1:0] irq_enable,
  input wire logic int_output_enable,
  input wire logic int_auto_clear,
  // Proximity measurements
  input wire logic [2:0] prox_done,
  input wire logic [MEAS_W-1:0] prox_a_value,
  input wire logic [MEAS_W-1:0] prox_b_value,
  input wire logic [MEAS_W-1:0] prox_c_value,
  input wire logic [MEAS_W-1:0] prox_a_threshold,
  input wire logic [MEAS_W-1:0] prox_b_threshold,
  input wire logic [MEAS_W-1:0] prox_c_threshold,
  // Ambient measurements
  input wire logic visible_done,
  input wire logic [MEAS_W-1:0] visible_light_channel,
  input wire logic infrared_done,
  input wire logic [MEAS_W-1:0] infrared_light_channel,
  input wire logic [MEAS_W-1:0] ambient_window_low,
  input wire logic [MEAS_W-1:0] ambient_window_high,
  // Response register writes
  input wire logic response_wr,
  input wire logic [7:0] response_data,
  // Status flags and host clear
  input wire logic [sicd_pkg::SICD_FLAG_W-1:0] flag_clear,
  output logic [sicd_pkg::SICD_FLAG_W-1:0] irq_flags_q,
  // Interrupt pin, open drain
  output logic int_pin_o_q,
  output logic int_pin_oe_q
);
  import sicd_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  logic [7:0] cond_a_q, cond_b_q;
  logic [2:0] prox_set, prox_above;
  logic [1:0] prox_mode [3];
  logic [MEAS_W-1:0] prox_val [3], prox_thr [3];
  logic [2:0] ambient_flag_condition;
  logic [1:0] ambient_irq_enable;
  logic [1:0] response_flag_condition;
  logic vis_in_q, ir_in_q, vis_seen_q, ir_seen_q;
  logic vis_in, ir_in;
  logic amb_done, amb_in, amb_prev_in, amb_seen;
  logic [SICD_FLAG_W-1:0] set_vec, auto_clr, flags_d;

  function automatic logic in_window(input logic [MEAS_W-1:0] v,
                                     input logic [MEAS_W-1:0] lo,
                                     input logic [MEAS_W-1:0] hi);
    in_window = (v >= lo) && (v <= hi);
  endfunction

  // ==========================================================
  // Condition registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cond_a_q <= SICD_COND_A_RST;
      cond_b_q <= SICD_COND_B_RST;
    end else if (reg_wr) begin
      if (reg_addr == SICD_COND_A_ADDR) begin
        // RQ4 reserved bit kept zero
        cond_a_q <= reg_wdata & SICD_COND_A_WMASK;
      end
      if (reg_addr == SICD_COND_B_ADDR) begin
        // RQ13 upper nibble reserved
        cond_b_q <= reg_wdata & SICD_COND_B_WMASK;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata_q <= 8'h00;
    end else if (reg_addr == SICD_COND_A_ADDR) begin
      reg_rdata_q <= cond_a_q;
    end else if (reg_addr == SICD_COND_B_ADDR) begin
      reg_rdata_q <= cond_b_q;
    end else begin
      reg_rdata_q <= 8'h00;
    end
  end

  assign prox_mode[0] = cond_a_q[SICD_PROX_A_POS +: 2];
  assign prox_mode[1] = cond_a_q[SICD_PROX_B_POS +: 2];
  assign prox_mode[2] = cond_b_q[SICD_PROX_C_POS +: 2];
  assign ambient_flag_condition = cond_a_q[SICD_AMB_POS +: 3];
  assign response_flag_condition = cond_b_q[SICD_RESP_POS +: 2];
  assign ambient_irq_enable = irq_enable[SICD_F_AMB1:SICD_F_AMB0];
  assign prox_val = '{prox_a_value, prox_b_value, prox_c_value};
  assign prox_thr = '{prox_a_threshold, prox_b_threshold, prox_c_threshold};

  // ==========================================================
  // Proximity channels
  for (genvar i = 0; i < 3; i++) begin : g_prox
    sicd_prox_cond #(
      .MEAS_W(MEAS_W)
    ) u_cond (
      .clk(clk),
      .rstn(rstn),
      .meas_done(prox_done[i]),
      .meas_value(prox_val[i]),
      .threshold(prox_thr[i]),
      .mode(prox_mode[i]),
      .set_flag(prox_set[i]),
      .above_now(prox_above[i])
    );
  end

  // ==========================================================
  // Ambient window tracking
  assign vis_in = in_window(visible_light_channel, ambient_window_low, ambient_window_high);
  assign ir_in = in_window(infrared_light_channel, ambient_window_low, ambient_window_high);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      vis_in_q <= 1'b0;
      vis_seen_q <= 1'b0;
    end else if (visible_done) begin
      vis_in_q <= vis_in;
      vis_seen_q <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ir_in_q <= 1'b0;
      ir_seen_q <= 1'b0;
    end else if (infrared_done) begin
      ir_in_q <= ir_in;
      ir_seen_q <= 1'b1;
    end
  end

  // Mode bit 1 picks infrared over visible
  assign amb_done = ambient_flag_condition[1] ? infrared_done : visible_done;
  assign amb_in = ambient_flag_condition[1] ? ir_in : vis_in;
  assign amb_prev_in = ambient_flag_condition[1] ? ir_in_q : vis_in_q;
  assign amb_seen = ambient_flag_condition[1] ? ir_seen_q : vis_seen_q;

  // ==========================================================
  // Flag set conditions
  always_comb begin
    set_vec = '0;
    // RQ1 prox A gated by enable
    set_vec[SICD_F_PROX_A] = irq_enable[SICD_F_PROX_A] && prox_set[0];
    // RQ2 prox B gated by enable
    set_vec[SICD_F_PROX_B] = irq_enable[SICD_F_PROX_B] && prox_set[1];
    // RQ3 prox C gated by enable
    set_vec[SICD_F_PROX_C] = irq_enable[SICD_F_PROX_C] && prox_set[2];
    // RQ5 every visible sample
    if (ambient_irq_enable == SICD_AE_VIS_ONLY && ambient_flag_condition == SICD_AM_EVERY) begin
      set_vec[SICD_F_AMB0] = visible_done;
    end
    // RQ10 window decoding only on later revisions
    if (WINDOW_DECODE) begin
      // RQ6 RQ7 window exit
      if (ambient_irq_enable[0] && ambient_flag_condition[0] && amb_done) begin
        set_vec[SICD_F_AMB0] = amb_seen && amb_prev_in && !amb_in;
      end
      // RQ8 RQ9 window entry
      if (ambient_irq_enable[1] && ambient_flag_condition[2] && amb_done) begin
        set_vec[SICD_F_AMB1] = amb_seen && !amb_prev_in && amb_in;
      end
    end
    // RQ11 RQ12 response write conditions
    if (irq_enable[SICD_F_RESP] && response_wr) begin
      set_vec[SICD_F_RESP] = (response_flag_condition == SICD_RM_EVERY) ||
        ((response_flag_condition == SICD_RM_ERROR) && response_data[SICD_RESP_ERR_BIT]);
    end
  end

  // RQ16 auto release when no longer above
  always_comb begin
    auto_clr = '0;
    for (int i = 0; i < 3; i++) begin
      auto_clr[SICD_F_PROX_A + i] = int_auto_clear && prox_mode[i] == SICD_PM_ABOVE &&
        prox_done[i] && !prox_above[i];
    end
  end

  // RQ15 sticky, set wins over clear
  assign flags_d = set_vec | (irq_flags_q & ~flag_clear & ~auto_clr);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_flags_q <= '0;
    end else begin
      irq_flags_q <= flags_d;
    end
  end

  // ==========================================================
  // Interrupt pin
  // RQ14 RQ17 drive low on any enabled flag
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      int_pin_oe_q <= 1'b0;
      int_pin_o_q <= 1'b0;
    end else begin
      int_pin_oe_q <= int_output_enable && |(flags_d & irq_enable);
      int_pin_o_q <= 1'b0;
    end
  end

  // ==========================================================
  // Assertions
  property p_prox_a_every;
    (irq_enable[SICD_F_PROX_A] && prox_done[0] && prox_mode[0] == SICD_PM_EVERY)
      |=> irq_flags_q[SICD_F_PROX_A];
  endproperty
  a_prox_a_every: assert property (p_prox_a_every) else $error("prox A not flagged"); // RQ1
  property p_prox_b_above;
    (irq_enable[SICD_F_PROX_B] && prox_done[1] && prox_mode[1] == SICD_PM_ABOVE &&
     prox_b_value > prox_b_threshold) |=> irq_flags_q[SICD_F_PROX_B];
  endproperty
  a_prox_b_above: assert property (p_prox_b_above) else $error("prox B above missed"); // RQ2
  property p_prox_c_disabled;
    (!irq_enable[SICD_F_PROX_C] && !irq_flags_q[SICD_F_PROX_C])
      |=> !irq_flags_q[SICD_F_PROX_C];
  endproperty
  a_prox_c_disabled: assert property (p_prox_c_disabled) else $error("prox C set unenabled"); // RQ3
  property p_amb_off;
    (ambient_irq_enable == 2'h0 && irq_flags_q[SICD_F_AMB1:SICD_F_AMB0] == 2'h0)
      |=> irq_flags_q[SICD_F_AMB1:SICD_F_AMB0] == 2'h0;
  endproperty
  a_amb_off: assert property (p_amb_off) else $error("ambient flag set while off"); // RQ4
  property p_amb_every;
    (ambient_irq_enable == SICD_AE_VIS_ONLY && ambient_flag_condition == SICD_AM_EVERY &&
     visible_done) |=> irq_flags_q[SICD_F_AMB0];
  endproperty
  a_amb_every: assert property (p_amb_every) else $error("visible sample not flagged"); // RQ5
  property p_resp_err;
    (irq_enable[SICD_F_RESP] && response_wr && response_flag_condition == SICD_RM_ERROR &&
     !response_data[SICD_RESP_ERR_BIT] && !irq_flags_q[SICD_F_RESP])
      |=> !irq_flags_q[SICD_F_RESP];
  endproperty
  a_resp_err: assert property (p_resp_err) else $error("non-error response flagged"); // RQ12
  property p_sticky;
    (irq_flags_q[SICD_F_RESP] && !flag_clear[SICD_F_RESP]) |=> irq_flags_q[SICD_F_RESP];
  endproperty
  a_sticky: assert property (p_sticky) else $error("response flag lost"); // RQ15
  property p_pin_follow;
    int_pin_oe_q == ($past(int_output_enable) && |(irq_flags_q & $past(irq_enable)));
  endproperty
  a_pin_follow: assert property (p_pin_follow) else $error("pin drive mismatch"); // RQ14
  property p_pin_low;
    ($past(int_output_enable) && |(irq_flags_q[SICD_F_AMB1:SICD_F_AMB0] &
     $past(ambient_irq_enable))) |-> int_pin_oe_q && !int_pin_o_q;
  endproperty
  a_pin_low: assert property (p_pin_low) else $error("pin not driven low"); // RQ17
  property p_cond_b_rsv;
    cond_b_q[7:4] == 4'h0;
  endproperty
  a_cond_b_rsv: assert property (p_cond_b_rsv) else $error("reserved bits set"); // RQ13
  c_auto_clear: cover property (irq_flags_q[SICD_F_PROX_A] ##1
    !irq_flags_q[SICD_F_PROX_A] && $past(auto_clr[SICD_F_PROX_A]));
  c_amb_enter: cover property ($rose(irq_flags_q[SICD_F_AMB1]));
  c_pin_drive: cover property ($rose(int_pin_oe_q));
endmodule
`default_nettype wire

// >>> rtl/sicd_pkg.sv
// Constants for the interrupt condition selector
package sicd_pkg;
  // ==========================================================
  // Register map
  localparam logic [7:0] SICD_COND_A_ADDR = 8'h05;
  localparam logic [7:0] SICD_COND_B_ADDR = 8'h06;
  localparam logic [7:0] SICD_COND_A_RST = 8'h00;
  localparam logic [7:0] SICD_COND_B_RST = 8'h00;
  localparam logic [7:0] SICD_COND_A_WMASK = 8'hf7;
  localparam logic [7:0] SICD_COND_B_WMASK = 8'h0f;
  // ==========================================================
  // Field positions (low bit of each field)
  localparam int SICD_PROX_B_POS = 6;
  localparam int SICD_PROX_A_POS = 4;
  localparam int SICD_AMB_POS = 0;
  localparam int SICD_RESP_POS = 2;
  localparam int SICD_PROX_C_POS = 0;
  // ==========================================================
  // Flag and enable bit positions
  localparam int SICD_FLAG_W = 6;
  localparam int SICD_F_AMB0 = 0;
  localparam int SICD_F_AMB1 = 1;
  localparam int SICD_F_PROX_A = 2;
  localparam int SICD_F_PROX_B = 3;
  localparam int SICD_F_PROX_C = 4;
  localparam int SICD_F_RESP = 5;
  // ==========================================================
  // Condition codes
  localparam logic [1:0] SICD_PM_EVERY = 2'h0;
  localparam logic [1:0] SICD_PM_CROSS = 2'h1;
  localparam logic [1:0] SICD_PM_ABOVE = 2'h3;
  localparam logic [1:0] SICD_RM_EVERY = 2'h0;
  localparam logic [1:0] SICD_RM_ERROR = 2'h1;
  localparam logic [2:0] SICD_AM_EVERY = 3'h0;
  localparam logic [1:0] SICD_AE_VIS_ONLY = 2'h1;
  localparam int SICD_RESP_ERR_BIT = 7;
endpackage

// >>> rtl/sicd_prox_cond.sv
// Per-channel proximity flag condition decoder
`timescale 1ns/100ps
`default_nettype none
module sicd_prox_cond #(
  parameter int MEAS_W = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Measurement
  input wire logic meas_done,
  input wire logic [MEAS_W-1:0] meas_value,
  input wire logic [MEAS_W-1:0] threshold,
  input wire logic [1:0] mode,
  // Decisions
  output logic set_flag,
  output logic above_now
);
  import sicd_pkg::*;

  logic prev_above_q;
  logic seen_q;

  assign above_now = meas_value > threshold;

  // ==========================================================
  // Previous comparison of this channel
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prev_above_q <= 1'b0;
      seen_q <= 1'b0;
    end else if (meas_done) begin
      prev_above_q <= above_now;
      seen_q <= 1'b1;
    end
  end

  // RQ18 crossing either way
  // RQ19 code 10 sets nothing
  always_comb begin
    set_flag = 1'b0;
    if (meas_done) begin
      unique case (mode)
        SICD_PM_EVERY: set_flag = 1'b1;
        SICD_PM_CROSS: set_flag = seen_q && (above_now != prev_above_q);
        SICD_PM_ABOVE: set_flag = above_now;
        default: set_flag = 1'b0;
      endcase
    end
  end
endmodule
`default_nettype wire

// >>> verification/sicd_host_model.sv
// Host model: register writes, reads and status flag clears
`timescale 1ns/100ps
`default_nettype none
module sicd_host_model (
  // Clock
  input wire logic clk,
  // Register access
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata_q,
  // Flag clear
  output logic [5:0] flag_clear
);
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    flag_clear = 6'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = (a == 8'h06) ? (d & 8'hf7) : d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    @(negedge clk);
    d = reg_rdata_q;
  endtask
  task automatic clr(input logic [5:0] m);
    @(negedge clk);
    flag_clear = m;
    @(negedge clk);
    flag_clear = 6'h00;
  endtask
endmodule
`default_nettype wire

// >>> verification/tb_top.sv
// Self-checking bench for the interrupt condition selector
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import sicd_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] reg_addr, reg_wdata, rdata, rdv;
  logic reg_wr;
  logic [5:0] irq_enable = 6'h00;
  logic [5:0] flag_clear, flags, expf;
  logic ioe = 1'b0;
  logic auto = 1'b0;
  logic [2:0] prox_done = 3'h0;
  logic [15:0] pv[3] = '{default: 16'h0};
  logic [15:0] th[3] = '{default: 16'h0};
  logic [15:0] cv[4] = '{16'd99, 16'd100, 16'd200, 16'd201};
  logic vis_done = 1'b0;
  logic ir_done = 1'b0;
  logic resp_wr = 1'b0;
  logic [15:0] vis_v = 16'h0;
  logic [15:0] ir_v = 16'h0;
  logic [15:0] wlo = 16'd100;
  logic [15:0] whi = 16'd200;
  logic [7:0] resp_d = 8'h00;
  logic pin_o, pin_oe;
  logic first[6], pst[6];
  int fail_count = 0;
  int samples_checked = 0;
  int seed = 43;
  int cycles = 0;

  always #20 clk = ~clk;

  sicd_host_model i_host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rdata_q(rdata), .flag_clear(flag_clear));

  sicd_irq_select #(.MEAS_W(16), .WINDOW_DECODE(1'b1)) i_dut (
    .clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rdata_q(rdata), .irq_enable(irq_enable),
    .int_output_enable(ioe), .int_auto_clear(auto), .prox_done(prox_done),
    .prox_a_value(pv[0]), .prox_b_value(pv[1]), .prox_c_value(pv[2]),
    .prox_a_threshold(th[0]), .prox_b_threshold(th[1]), .prox_c_threshold(th[2]),
    .visible_done(vis_done), .visible_light_channel(vis_v), .infrared_done(ir_done),
    .infrared_light_channel(ir_v), .ambient_window_low(wlo), .ambient_window_high(whi),
    .response_wr(resp_wr), .response_data(resp_d), .flag_clear(flag_clear),
    .irq_flags_q(flags), .int_pin_o_q(pin_o), .int_pin_oe_q(pin_oe));

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      fail_count++;
      $display("BAD %0t timeout", $time);
      tally_and_finish();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chkf();
    chk({2'b00, flags}, {2'b00, expf});
    chk({6'h00, pin_o, pin_oe}, {7'h00, ioe & (|(expf & irq_enable))});
  endtask

  task automatic do_reset();
    @(negedge clk);
    rstn = 1'b0;
    repeat (10) @(negedge clk);
    rstn = 1'b1;
    expf = 6'h00;
    for (int i = 0; i < 6; i++) first[i] = 1'b1;
  endtask

  // Kind: 0 visible, 1 infrared, 2..4 proximity, 5 response; kinds 2..5 match flag bits
  task automatic pulse(input int k, input logic [15:0] v);
    @(negedge clk);
    if (k == 0) begin
      vis_v = v;
      vis_done = 1'b1;
    end else if (k == 1) begin
      ir_v = v;
      ir_done = 1'b1;
    end else if (k < 5) begin
      pv[k - 2] = v;
      prox_done[k - 2] = 1'b1;
    end else begin
      resp_d = v[7:0];
      resp_wr = 1'b1;
    end
    @(negedge clk);
    prox_done = 3'h0;
    vis_done = 1'b0;
    ir_done = 1'b0;
    resp_wr = 1'b0;
  endtask

  function automatic logic [1:0] amb_exp(logic [1:0] en, logic [2:0] md, int ch,
      logic was_in, logic now_in, logic fst);
    logic [1:0] r;
    r = 2'b00;
    if (en == 2'b01 && md == 3'b000 && ch == 0) r[0] = 1'b1;
    if (en[0] && md[0] && md[1] == ch[0] && !fst && was_in && !now_in) r[0] = 1'b1;
    if (en[1] && md[2] && md[1] == ch[0] && !fst && !was_in && now_in) r[1] = 1'b1;
    return r;
  endfunction

  initial begin
    logic [15:0] v;
    logic ab, set, now_in;
    int k;
    do_reset();
    i_host.rd(8'h06, rdv);
    chk(rdv, SICD_COND_B_RST);
    i_host.wr(8'h05, 8'hff);
    i_host.wr(8'h06, 8'hff);
    i_host.wr(8'h07, 8'h5a);
    i_host.rd(8'h05, rdv);
    chk(rdv, 8'hf7);
    i_host.rd(8'h06, rdv);
    chk(rdv, 8'h07);
    i_host.rd(8'h07, rdv);
    chk(rdv, 8'h00);
    $display("test registers done");
    for (int m = 0; m < 4; m++) begin
      do_reset();
      i_host.wr(8'h05, {m[1:0], m[1:0], 4'h0});
      i_host.wr(8'h06, {5'h00, m[0], m[1:0]});
      for (int i = 0; i < 3; i++) th[i] = 16'($random(seed));
      repeat (40) begin
        k = 2 + (($random(seed) & 32'h7fff) % 4);
        v = 16'($random(seed));
        if (k < 5 && ($random(seed) & 7) == 0) v = th[k - 2];
        irq_enable = 6'($random(seed));
        ioe = 1'($random(seed));
        auto = 1'($random(seed));
        if (k < 5) begin
          ab = v > th[k - 2];
          set = irq_enable[k] && (m == 0 || (m == 3 && ab) ||
                (m == 1 && !first[k] && ab != pst[k]));
          if (auto && m == 3 && !ab) expf[k] = 1'b0;
          first[k] = 1'b0;
          pst[k] = ab;
        end else begin
          set = irq_enable[5] && (m[0] == 1'b0 || v[7]);
        end
        expf[k] = expf[k] | set;
        pulse(k, v);
        chkf();
        if ($random(seed) & 1) begin
          i_host.clr(6'h3f);
          expf = 6'h00;
          chkf();
        end
      end
      $display("test prox mode %0d done", m);
    end
    ioe = 1'b1;
    auto = 1'b0;
    for (int md = 0; md < 8; md++) begin
      do_reset();
      i_host.wr(8'h05, {5'h00, md[2:0]});
      repeat (12) begin
        irq_enable = 6'($random(seed));
        if (md == 0 && ($random(seed) & 1)) irq_enable[1:0] = 2'b01;
        k = $random(seed) & 1;
        v = (($random(seed) & 3) == 0) ? cv[$random(seed) & 3]
            : 16'(($random(seed) & 32'h7fff) % 300);
        now_in = v >= wlo && v <= whi;
        expf[1:0] = expf[1:0] | amb_exp(irq_enable[1:0], md[2:0], k, pst[k], now_in, first[k]);
        first[k] = 1'b0;
        pst[k] = now_in;
        pulse(k, v);
        chkf();
        if ($random(seed) & 1) begin
          i_host.clr(6'h3f);
          expf = 6'h00;
          chkf();
        end
      end
      $display("test ambient mode %0d done", md);
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire
